// ### hw/gpio_port_zero_params.svh
// Offsets, field positions and reset values of the port zero pin controller.
// Included by its bare name; holds definitions only.
`ifndef GPIO_PORT_ZERO_PARAMS_SVH
`define GPIO_PORT_ZERO_PARAMS_SVH

// ==========================================================================
// Register offsets on the plain register port
`define GP0_ADDR_W        4
`define GP0_OFS_DATA      4'h0
`define GP0_OFS_DIR       4'h1
`define GP0_OFS_AIDR      4'h2
`define GP0_OFS_CTRL      4'h3

// ==========================================================================
// Reset values
`define GP0_RST_DATA      8'h00
`define GP0_RST_DIR       8'h00
`define GP0_RST_AIDR      8'h00
`define GP0_RST_CTRL      2'h0

// ==========================================================================
// Control register fields
`define GP0_CTRL_PINSTATE_BIT  0
`define GP0_CTRL_PORTIN_BIT    1
`define GP0_CTRL_ST_LO      2
`define GP0_CTRL_ST_HI      3

// ==========================================================================
// Pins shared with other functions, and pin synchroniser depth
`define GP0_LCD_MASK      8'hFE
`define GP0_ANA_MASK      8'hFF
`define GP0_SYNC_STAGES   2

`endif

// ### hw/gpio_port_zero_pkg.sv
// Types shared by the port zero pin controller and its helpers.
// Assumes an 8-bit port; constants live in the params header.
package gpio_port_zero_pkg;

    // ======================================================================
    // Standby handling of the pins
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_HOLD = 2'b01,
        ST_HIZ  = 2'b10
    } standby_state_e;

    // ======================================================================
    // One register access as seen by the port
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       read_modify_write_access;
    } bus_req_s;

    // ======================================================================
    // Drive of the eight pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_s;

endpackage

// ### hw/pin_sync.sv
// Two-stage synchroniser for the port pins.
// Assumes the inputs are asynchronous to clk; ce freezes both stages.
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output      logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ======================================================================
    // First stage is read only by the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (ce)
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule

// ### hw/pin_drive_mux.sv
// Per-pin selection of what drives each port pin.
// Pure combinational; the caller registers the result and applies standby.
module pin_drive_mux (
    input  wire logic [7:0]                    latch,
    input  wire logic [7:0]                    dir,
    input  wire logic [7:0]                    periph_oe,
    input  wire logic [7:0]                    periph_out,
    input  wire logic [7:0]                    seg_act,
    input  wire logic [7:0]                    seg_out,
    output      gpio_port_zero_pkg::pin_drive_s drive
);

    logic [7:0] per_only;
    logic [7:0] port_only;

    // ======================================================================
    // Segment beats peripheral, peripheral beats the port latch
    assign per_only  = periph_oe & ~seg_act;
    assign port_only = dir & ~periph_oe & ~seg_act;

    assign drive.out = (seg_act & seg_out) | (per_only & periph_out) | (port_only & latch);
    assign drive.oe  = seg_act | per_only | port_only;

endmodule

// ### hw/gpio_port_zero.sv
// Port zero pin controller: data latch, direction, analog input disable,
// read paths for plain and read-modify-write reads, and standby pin handling.
// Assumes pins arrive asynchronously, peripherals and the register master on clk.
`include "gpio_port_zero_params.svh"

// Notes on behaviour
// - Direction bit one makes the pin an output driving the latch bit.
// - An output pin's level follows the stored latch bit.
// - Writes always load the latch; input pins do not show it.
// - Plain read of an output pin returns its latch bit.
// - Direction bit zero makes an input; plain read returns the pin level.
// - Read-modify-write reads return the latch, never the pins.
// - A peripheral output enable routes that peripheral onto the pin.
// - Plain read of a peripheral-driven pin returns the actual pin level.
// - Plain read returns pin level even while a peripheral consumes it.
// - Analog disable bit zero blocks digital input; one enables it.
// - Bit n of the data, direction and analog disable registers controls pin n, bits seven to zero.
// - All three registers reset to zero, so pins start as inputs.
// - Standby with select one: pins float, inputs low unless interrupt enabled.
// - Standby with select zero: pin states and output levels are held.
// - The pin level reaches the external interrupt circuit, except on non-enabled pins in floating standby.
module gpio_port_zero #(
    parameter logic [7:0] LCD_MASK = `GP0_LCD_MASK,
    parameter logic [7:0] ANA_MASK = `GP0_ANA_MASK
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire logic [`GP0_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic                    reg_rmw,
    output      logic [7:0]              reg_rdata,
    input  wire logic [7:0]              pin_in,
    output      logic [7:0]              pin_out,
    output      logic [7:0]              pin_oe,
    input  wire logic [7:0]              periph_oe,
    input  wire logic [7:0]              periph_out,
    input  wire logic [7:0]              seg_sel,
    input  wire logic [7:0]              seg_out,
    input  wire logic                    standby_req,
    input  wire logic [7:0]              ext_int_en,
    output      logic [7:0]              digital_in,
    output      logic [7:0]              ext_int_in
);

    gpio_port_zero_pkg::bus_req_s       req;
    gpio_port_zero_pkg::pin_drive_s     drv_sel;
    gpio_port_zero_pkg::standby_state_e st_q;
    gpio_port_zero_pkg::standby_state_e st_d;

    logic [7:0] latch_q;
    logic [7:0] dir_q;
    logic [7:0] aidr_q;
    logic [1:0] ctrl_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] out_q;
    logic [7:0] oe_q;
    logic [7:0] out_d;
    logic [7:0] oe_d;
    logic [7:0] pin_s;
    logic [7:0] seg_act;
    logic [7:0] dig_en;
    logic [7:0] hiz_keep;
    logic [7:0] pin_rd;
    logic [7:0] port_rd;
    logic [7:0] ctrl_rd;
    logic       hit_data;
    logic       hit_dir;
    logic       hit_aidr;
    logic       hit_ctrl;
    logic       pin_state_sel;
    logic       port_in_en;
    logic       hiz;

    // ======================================================================
    // Register port bundled for decoding
    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;
    assign req.read_modify_write_access   = reg_rmw;

    // Address decode
    assign hit_data = (req.addr == `GP0_OFS_DATA);
    assign hit_dir  = (req.addr == `GP0_OFS_DIR);
    assign hit_aidr = (req.addr == `GP0_OFS_AIDR);
    assign hit_ctrl = (req.addr == `GP0_OFS_CTRL);
    assign pin_state_sel = ctrl_q[`GP0_CTRL_PINSTATE_BIT];
    assign port_in_en    = ctrl_q[`GP0_CTRL_PORTIN_BIT];

    // ======================================================================
    // Pin inputs cross into clk before anything reads them
    pin_sync #(
        .WIDTH (8)
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (pin_in),
        .q     (pin_s)
    );

    // ======================================================================
    // Segment function only exists on the LCD-shared pins
    // segment takes precedence
    assign seg_act = seg_sel & LCD_MASK;

    // Output selection per pin
    // peripheral onto pin
    pin_drive_mux u_pin_drive_mux (
        .latch      (latch_q),
        .dir        (dir_q),
        .periph_oe  (periph_oe),
        .periph_out (periph_out),
        .seg_act    (seg_act),
        .seg_out    (seg_out),
        .drive      (drv_sel)
    );

    // ======================================================================
    // Standby sequencing; select bit is sampled when standby begins
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            gpio_port_zero_pkg::ST_RUN:
                if (standby_req)
                    st_d = pin_state_sel ? gpio_port_zero_pkg::ST_HIZ : gpio_port_zero_pkg::ST_HOLD;
            gpio_port_zero_pkg::ST_HOLD,
            gpio_port_zero_pkg::ST_HIZ:
                if (!standby_req)
                    st_d = gpio_port_zero_pkg::ST_RUN;
            default:
                st_d = gpio_port_zero_pkg::ST_RUN;
        endcase
    end

    assign hiz = (st_q == gpio_port_zero_pkg::ST_HIZ);

    // ======================================================================
    // Registered pin drive: floats in one standby kind, frozen in the other
    // float in standby
    assign out_d = (st_d == gpio_port_zero_pkg::ST_RUN) ? drv_sel.out : out_q;
    assign oe_d  = (st_d == gpio_port_zero_pkg::ST_HIZ) ? 8'h00 :
                   (st_d == gpio_port_zero_pkg::ST_RUN) ? drv_sel.oe : oe_q;

    // ======================================================================
    // Digital input gating: analog pins and LCD pins need enabling first
    // analog disable gating
    assign dig_en   = (~ANA_MASK | aidr_q) & (~LCD_MASK | {8{port_in_en}}) & ~seg_act & hiz_keep;
    // Interrupt-enabled pins stay live so they can still wake the part
    // inputs forced low
    assign hiz_keep = hiz ? ext_int_en : 8'hFF;
    assign pin_rd   = pin_s & dig_en;
    assign digital_in = pin_rd;
    assign ext_int_in = pin_s & (hiz_keep | ext_int_en);

    // ======================================================================
    // Read data: latch for own-driven outputs or READ_MODIFY_WRITE_ACCESS, pin level otherwise
    // output reads latch
    assign port_rd = req.read_modify_write_access ? latch_q :
                     ((dir_q & ~periph_oe & ~seg_act & latch_q) | (~(dir_q & ~periph_oe & ~seg_act) & pin_rd));
    // Standby state readable so software can tell which kind was taken
    assign ctrl_rd = {4'h0, st_q, ctrl_q};
    assign rdata_d = !req.rd  ? 8'h00   :
                     hit_data ? port_rd :
                     hit_dir  ? dir_q   :
                     hit_aidr ? aidr_q  :
                     hit_ctrl ? ctrl_rd : 8'h00;

    // ======================================================================
    // Software registers; a latch write lands whatever the direction
    // write always loads
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latch_q <= `GP0_RST_DATA;
            dir_q   <= `GP0_RST_DIR;
            aidr_q  <= `GP0_RST_AIDR;
            ctrl_q  <= `GP0_RST_CTRL;
        end
        else if (ce && req.wr)
        begin
            if (hit_data) latch_q <= req.wdata;
            if (hit_dir)  dir_q   <= req.wdata;
            if (hit_aidr) aidr_q  <= req.wdata;
            if (hit_ctrl) ctrl_q  <= req.wdata[1:0];
        end
    end

    // ======================================================================
    // Pin drive, standby state and read data flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q   <= 8'h00;
            oe_q    <= 8'h00;
            st_q    <= gpio_port_zero_pkg::ST_RUN;
            rdata_q <= 8'h00;
        end
        else if (ce)
        begin
            out_q   <= out_d;
            oe_q    <= oe_d;
            st_q    <= st_d;
            rdata_q <= rdata_d;
        end
    end

    assign pin_out   = out_q;
    assign pin_oe    = oe_q;
    assign reg_rdata = rdata_q;

    // ======================================================================
    // Checks
    logic [7:0] own_drv;
    assign own_drv = dir_q & ~periph_oe & ~seg_act;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_OUT_DRIVES_LATCH: assert property (
        (ce && st_q == gpio_port_zero_pkg::ST_RUN && !standby_req)
        |=> ((((pin_out ^ $past(latch_q)) & $past(own_drv)) == 8'h00) && ((pin_oe & $past(own_drv)) == $past(own_drv))))
        else $error("output pin does not drive its latch bit");

    AST_LATCH_FOLLOW: assert property (
        (ce && req.wr && hit_data && st_q == gpio_port_zero_pkg::ST_RUN && !standby_req && own_drv == 8'hFF)
        ##1 (ce && !standby_req && own_drv == 8'hFF) |=> (pin_out == $past(req.wdata, 2)))
        else $error("output pins do not follow a written latch");

    AST_WRITE_INPUT_HIDDEN: assert property (
        (ce && req.wr && hit_data)
        |=> (latch_q == $past(req.wdata)) && ((pin_oe & ~$past(dir_q | periph_oe | seg_act)) == 8'h00))
        else $error("latch write lost or shown on an input pin");

    AST_PLAIN_READ: assert property (
        (ce && req.rd && hit_data && !req.read_modify_write_access)
        |=> reg_rdata == (($past(own_drv) & $past(latch_q)) | (~$past(own_drv) & $past(pin_rd))))
        else $error("plain read of the data register returned the wrong source");

    AST_RMW_READ: assert property (
        (ce && req.rd && hit_data && req.read_modify_write_access) |=> reg_rdata == $past(latch_q))
        else $error("read-modify-write read did not return the latch");

    AST_PERIPH_ROUTE: assert property (
        (ce && st_q == gpio_port_zero_pkg::ST_RUN && !standby_req)
        |=> (((pin_out ^ $past(periph_out)) & $past(periph_oe & ~seg_act)) == 8'h00))
        else $error("peripheral output not routed to its pin");

    AST_ANALOG_BLOCK: assert property (
        ((digital_in & ANA_MASK & ~aidr_q) == 8'h00))
        else $error("digital input seen on an analog-selected pin");

    AST_RESET_ZERO: assert property (disable iff (1'b0)
        (!rst_n && !$past(rst_n)) |-> (latch_q == 8'h00 && dir_q == 8'h00 && aidr_q == 8'h00))
        else $error("port registers not zero under reset");

    AST_HIZ_FLOAT: assert property (
        (st_q == gpio_port_zero_pkg::ST_HIZ) |-> (pin_oe == 8'h00) && ((digital_in & ~ext_int_en) == 8'h00))
        else $error("pins not floated or inputs not blocked in standby");

    AST_HOLD_LEVELS: assert property (
        (st_q == gpio_port_zero_pkg::ST_HOLD) |-> ($stable(pin_out) && $stable(pin_oe)))
        else $error("pin levels moved during held standby");

    AST_INT_LEVEL: assert property (
        (((ext_int_in ^ pin_s) & ext_int_en) == 8'h00))
        else $error("interrupt input does not carry the pin level");

    AST_SEG_WINS: assert property (
        (ce && st_q == gpio_port_zero_pkg::ST_RUN && !standby_req)
        |=> ((((pin_out ^ $past(seg_out)) & $past(seg_act)) == 8'h00) && ((pin_oe & $past(seg_act)) == $past(seg_act))))
        else $error("segment function did not take the pin");

    // Main scenarios reached
    COV_RMW_READ:   cover property (ce && req.rd && hit_data && req.read_modify_write_access);
    COV_FROZEN_WR:  cover property (!ce && req.wr && hit_data);
    COV_HIZ_ENTRY:  cover property (st_q == gpio_port_zero_pkg::ST_RUN ##1 st_q == gpio_port_zero_pkg::ST_HIZ);
    COV_HOLD_ENTRY: cover property (st_q == gpio_port_zero_pkg::ST_RUN ##1 st_q == gpio_port_zero_pkg::ST_HOLD);
    COV_PERIPH_PIN: cover property (ce && (periph_oe & ~seg_act) != 8'h00 && req.rd && hit_data);

endmodule

// ### verif/pad_model.sv
// Pad ring and far-side drivers of port zero.
// Assumes clk is the block clock; ext_en marks the bits that an outside source drives.
module pad_model (
    input  wire logic       clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output      logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] float_q = 8'h55;

    // ======================================================================
    // Undriven pads wander, so a stale level never passes for a valid one
    always @(posedge clk)
    begin
        float_q <= ~float_q;
    end

    // outside drivers yield
    // The port wins wherever it drives; the outside source only fills the gaps
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & float_q);
endmodule

// ### verif/tb_gpio_port_zero.sv
// Self-checking bench of the port zero pin controller.
// Assumes the pad model closes the pin loop; ce drops once to show frozen state.
`include "gpio_port_zero_params.svh"

module tb_gpio_port_zero;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk;
    logic       rst_n;
    logic       ce;
    logic       reg_wr;
    logic       reg_rd;
    logic       reg_rmw;
    logic       standby_req;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, periph_oe, periph_out;
    logic [7:0] seg_sel, seg_out, ext_int_en, digital_in, ext_int_in, ext_val, ext_en;
    int         mismatches;
    int         cmp_count;

    // ======================================================================
    // Design and pads
    gpio_port_zero uut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_oe(periph_oe),
        .periph_out(periph_out), .seg_sel(seg_sel), .seg_out(seg_out),
        .standby_req(standby_req), .ext_int_en(ext_int_en), .digital_in(digital_in),
        .ext_int_in(ext_int_in)
    );
    pad_model pads (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en),
        .pin_in(pin_in)
    );

    // ======================================================================
    // Clock, 25 ns period
    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    // ======================================================================
    // Shared helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clk);
        reg_wr    <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample it there
    task automatic rchk(input logic [3:0] a, input logic m, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rmw  <= m;
        reg_rd   <= 1'h1;
        @(posedge clk);
        reg_rd   <= 1'h0;
        reg_rmw  <= 1'h0;
        #1;
        chk(reg_rdata, exp, what);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset;
        rchk(`GP0_OFS_DATA, 1'h1, 8'h00, "latch after reset");
        rchk(`GP0_OFS_DIR, 1'h0, 8'h00, "direction after reset");
        rchk(`GP0_OFS_AIDR, 1'h0, 8'h00, "analog disable after reset");
        rchk(`GP0_OFS_CTRL, 1'h0, 8'h00, "control after reset");
        chk(pin_oe, 8'h00, "all pins inputs after reset");
    endtask

    task automatic t_output;
        wr(`GP0_OFS_DIR, 8'h0F);
        wr(`GP0_OFS_DATA, 8'h5A);
        idle(2);
        chk(pin_oe, 8'h0F, "low nibble driven");
        chk(pin_out & 8'h0F, 8'h0A, "pins follow latch bit by bit");
        // Upper inputs stay blocked while analog disable is zero
        rchk(`GP0_OFS_DATA, 1'h0, 8'h0A, "mixed read");
        wr(`GP0_OFS_DIR, 8'hFF);
        idle(2);
        chk(pin_out, 8'h5A, "all pins follow latch");
        rchk(`GP0_OFS_DATA, 1'h0, 8'h5A, "output read gives latch");
    endtask

    task automatic t_input;
        wr(`GP0_OFS_DIR, 8'h00);
        wr(`GP0_OFS_AIDR, 8'hFF);
        // standby select zero, port input on
        wr(`GP0_OFS_CTRL, 8'h02);
        ext_en  <= 8'hFF;
        ext_val <= 8'h3D;
        idle(4);
        rchk(`GP0_OFS_DATA, 1'h0, 8'h3D, "input read gives pins");
        rchk(`GP0_OFS_DATA, 1'h1, 8'h5A, "rmw read gives latch");
        chk(digital_in, 8'h3D, "digital input to peripherals");
        wr(`GP0_OFS_DATA, 8'hC3);
        idle(2);
        chk(pin_oe, 8'h00, "latch hidden on inputs");
        rchk(`GP0_OFS_DATA, 1'h1, 8'hC3, "latch loaded anyway");
        wr(`GP0_OFS_AIDR, 8'hF0);
        idle(2);
        rchk(`GP0_OFS_DATA, 1'h0, 8'h30, "analog pins block input");
        chk(ext_int_in, 8'h3D, "interrupt path ungated");
        wr(`GP0_OFS_AIDR, 8'hFF);
        wr(`GP0_OFS_CTRL, 8'h00);
        idle(2);
        rchk(`GP0_OFS_DATA, 1'h0, 8'h01, "segment pins blocked without port input");
        wr(`GP0_OFS_CTRL, 8'h02);
    endtask

    task automatic t_periph;
        @(posedge clk);
        periph_oe  <= 8'h11;
        periph_out <= 8'h10;
        idle(4);
        chk(pin_oe, 8'h11, "peripheral takes pins");
        chk(pin_out & 8'h11, 8'h10, "peripheral value on pins");
        rchk(`GP0_OFS_DATA, 1'h0, 8'h3C, "plain read sees peripheral level");
        rchk(`GP0_OFS_DATA, 1'h1, 8'hC3, "rmw read still latch");
        @(posedge clk);
        periph_oe <= 8'h00;
    endtask

    task automatic t_seg;
        @(posedge clk);
        seg_sel <= 8'h81;
        seg_out <= 8'h00;
        wr(`GP0_OFS_DIR, 8'hFF);
        idle(2);
        // Pin zero has no segment, so its select bit must do nothing
        chk(pin_out, 8'h43, "segment overrides latch on pin seven only");
        @(posedge clk);
        seg_sel <= 8'h00;
        idle(2);
    endtask

    task automatic t_standby;
        wr(`GP0_OFS_CTRL, 8'h03);
        ext_int_en  <= 8'h01;
        standby_req <= 1'h1;
        idle(2);
        chk(pin_oe, 8'h00, "pins float in standby");
        idle(3);
        chk(digital_in, 8'h01, "inputs forced low unless interrupt");
        chk(ext_int_in, 8'h01, "enabled interrupt input kept");
        rchk(`GP0_OFS_CTRL, 1'h0, 8'h0B, "state shows floating standby");
        @(posedge clk);
        standby_req <= 1'h0;
        idle(2);
        chk(pin_oe, 8'hFF, "drive resumes");
        wr(`GP0_OFS_CTRL, 8'h02);
        standby_req <= 1'h1;
        idle(2);
        wr(`GP0_OFS_DATA, 8'h18);
        idle(2);
        chk(pin_out, 8'hC3, "levels held in standby");
        chk(pin_oe, 8'hFF, "drive held in standby");
        @(posedge clk);
        standby_req <= 1'h0;
        idle(2);
        chk(pin_out, 8'h18, "new latch after wake");
    endtask

    // Clock enable low: a write must not land and the drive must not move
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'h0;
        wr(`GP0_OFS_DATA, 8'hA5);
        idle(2);
        chk(pin_out, 8'h18, "drive frozen while clock enable low");
        @(posedge clk);
        ce <= 1'h1;
        rchk(`GP0_OFS_DATA, 1'h1, 8'h18, "write ignored while clock enable low");
    endtask

    task automatic t_unmapped;
        wr(4'h7, 8'h00);
        rchk(4'h5, 1'h0, 8'h00, "unmapped read");
        rchk(`GP0_OFS_DIR, 1'h0, 8'hFF, "direction untouched");
        rchk(`GP0_OFS_AIDR, 1'h0, 8'hFF, "analog disable untouched");
    endtask

    // ======================================================================
    // Verdict, reached from the main sequence or the watchdog
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog so a stuck sequence still ends with a verdict
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    // Main sequence; reset held twelve cycles
    initial
    begin
        mismatches  = 0;
        cmp_count   = 0;
        rst_n       = 1'h0;
        ce          = 1'h1;
        reg_wr      = 1'h0;
        reg_rd      = 1'h0;
        reg_rmw     = 1'h0;
        reg_addr    = 4'h0;
        reg_wdata   = 8'h00;
        standby_req = 1'h0;
        periph_oe   = 8'h00;
        periph_out  = 8'h00;
        seg_sel     = 8'h00;
        seg_out     = 8'h00;
        ext_int_en  = 8'h00;
        ext_val     = 8'h00;
        ext_en      = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_output();
        t_input();
        t_periph();
        t_seg();
        t_standby();
        t_freeze();
        t_unmapped();
        report_and_stop();
    end
endmodule
